// [qpts_pkg.sv]
package qpts_pkg;
    localparam logic [3:0] QPTS_TYPE_CODE = 4'h9; // Arbitrary value, stands in for the fixed type code.
    localparam int QPTS_CLK_HZ = 40000000;
    localparam int QPTS_NV_WRITE_US = 5000;
    localparam int QPTS_NV_WRITE_CYC = QPTS_NV_WRITE_US * (QPTS_CLK_HZ / 1000000);
    localparam logic [5:0] QPTS_WIPER_RST = 6'h00;
    localparam logic [3:0] QPTS_OP_RD_WIPER = 4'h9;
    localparam logic [3:0] QPTS_OP_WR_WIPER = 4'hA;
    localparam logic [3:0] QPTS_OP_RD_DATA = 4'hB;
    localparam logic [3:0] QPTS_OP_WR_DATA = 4'hC;
    localparam logic [3:0] QPTS_OP_XFR_D2W = 4'hD;
    localparam logic [3:0] QPTS_OP_XFR_W2D = 4'hE;
    localparam logic [3:0] QPTS_OP_GXFR_D2W = 4'h1;
    localparam logic [3:0] QPTS_OP_GXFR_W2D = 4'h8;
    localparam logic [3:0] QPTS_OP_STEP = 4'h2;
    localparam int QPTS_TAPS = 64;
    localparam int QPTS_SEGMENTS = QPTS_TAPS - 1;

    typedef struct packed {
        logic [3:0] opcode;
        logic preset_select_hi;
        logic preset_select_lo;
        logic pot_select_hi;
        logic pot_select_lo;
    } qpts_instr_s;

    typedef struct packed {
        logic valid;
        logic [1:0] pot;
        logic [1:0] preset;
        logic [3:0] opcode;
        logic [5:0] data;
    } qpts_cmd_s;
endpackage

// [qpts_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module qpts_sync
    import qpts_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic clk_in, // Destination clock
    input wire logic [WIDTH-1:0] d_in, // Asynchronous level
    output logic [WIDTH-1:0] q_out // Synchronised level
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk_in)
    begin
        meta_q <= d_in;
        q_out <= meta_q;
    end
endmodule
`default_nettype wire

// [qpts_tap_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module qpts_tap_decode
    import qpts_pkg::*;
(
    input wire logic clk_in, // System clock
    input wire logic [5:0] wiper_in, // Wiper position
    output logic [QPTS_TAPS-1:0] tap_on_out // One-hot tap switches
);
    // A tap sits at each end and between each of the segments.
    logic [QPTS_TAPS-1:0] onehot;
    assign onehot = {{(QPTS_TAPS-1){1'b0}}, 1'b1} << wiper_in;
    always_ff @(posedge clk_in)
    begin
        tap_on_out <= onehot;
    end
endmodule
`default_nettype wire

// [qpts_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module qpts_slave
    import qpts_pkg::*;
#(
    parameter int NV_WRITE_CYC = QPTS_NV_WRITE_CYC
)(
    input wire logic ref_clk_in, // System clock, 40 MHz
    input wire logic sys_rst_in, // Synchronous reset, active high
    input wire logic bus_clk_in, // Serial clock from the master
    input wire logic sda_in, // Serial data line level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe_n_out, // Low while pulling the data line low
    input wire logic [3:0] strap_address_pins_in, // Strapped device address
    input wire logic write_protect_n_in, // Low blocks nonvolatile writes
    input wire logic [5:0] read_data_in, // Value shifted out on reads
    output logic [3:0][5:0] wiper_position_reg_out, // Four wiper positions
    output logic [3:0][QPTS_TAPS-1:0] tap_on_out, // One-hot taps per array
    output qpts_cmd_s cmd_out, // Decoded command, valid one cycle
    output logic nv_busy_out // Internal nonvolatile write in progress
);
    // ==============================================================
    // Link domain: the serial engine runs on the bus clock.
    // ==============================================================
    // Start and stop are sampled as edges of data, seen on the data line
    // itself, so a short async detector toggles flags that the clock side compares with its own copies.
    typedef enum {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_STEP, ST_READ} qpts_state_e;
    // The bus side has no reset pin, so its control bits power up idle.
    // The first start condition then puts the engine in a known state.
    qpts_state_e state_q = ST_IDLE;
    logic [3:0] bitcnt_q = 4'h0;
    logic [7:0] shift_q;
    logic ack_q = 1'b0;
    logic drive_q = 1'b0;
    qpts_instr_s instr_q;
    logic [5:0] rd_q;
    logic start_tgl_q = 1'b0;
    logic start_seen_q = 1'b0;
    logic stop_tgl_q = 1'b0;
    logic stop_seen_q = 1'b0;
    logic cmd_tgl_q = 1'b0;
    qpts_cmd_s cmd_link_q;
    logic busy_link;
    logic [3:0] addr_type;
    logic [3:0] addr_dev;
    logic addr_match;
    logic cmd_has_data;
    logic step_dir_q = 1'b0;
    logic step_tgl_q = 1'b0;
    logic nv_cmd_q = 1'b0;
    logic [7:0] shifted;
    logic [3:0] strap_sync;
    logic [5:0] read_data_sync;
    logic instr_is_nv;
    logic instr_is_read;
    logic instr_is_step;
    logic [7:0] read_byte;
    logic read_pull;

    // ==============================================================
    // Opcode classes.
    // ==============================================================
    function automatic logic op_is_nv(input logic [3:0] op);
        return (op == QPTS_OP_WR_DATA) || (op == QPTS_OP_XFR_W2D) || (op == QPTS_OP_GXFR_W2D);
    endfunction
    function automatic logic op_is_read(input logic [3:0] op);
        return (op == QPTS_OP_RD_WIPER) || (op == QPTS_OP_RD_DATA);
    endfunction
    function automatic logic op_has_data(input logic [3:0] op);
        return (op == QPTS_OP_WR_WIPER) || (op == QPTS_OP_WR_DATA);
    endfunction

    // Start: falling data while clock high; stop: rising data while high.
    always_ff @(negedge sda_in)
    begin
        if (bus_clk_in)
        begin
            start_tgl_q <= ~start_tgl_q;
        end
    end
    always_ff @(posedge sda_in)
    begin
        if (bus_clk_in)
        begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    assign shifted = {shift_q[6:0], sda_in};
    assign addr_type = shifted[7:4];
    assign addr_dev = shifted[3:0];
    assign addr_match = (addr_type == QPTS_TYPE_CODE) && (addr_dev == strap_sync) &&
                        !busy_link;
    assign cmd_has_data = op_has_data(instr_q.opcode);
    assign instr_is_nv = op_is_nv(instr_q.opcode);
    assign instr_is_read = op_is_read(instr_q.opcode);
    assign instr_is_step = (instr_q.opcode == QPTS_OP_STEP);

    // The six-bit value leaves as the low bits of a byte whose top two bits are zero.
    assign read_byte = {2'b00, rd_q};
    assign read_pull = (state_q == ST_READ) && (bitcnt_q < 4'h8) &&
                       !read_byte[3'(4'h7 - bitcnt_q)];

    // Straps and the read value are levels from outside the bus clock's domain.
    // They are only looked at mid-frame, so two bus clocks of lag cost nothing.
    qpts_sync #(.WIDTH(10)) u_link_sync
    (
        .clk_in(bus_clk_in),
        .d_in({strap_address_pins_in, read_data_in}),
        .q_out({strap_sync, read_data_sync})
    );
    // Busy must be settled by the eighth address bit; a poll has seven clocks before it.
    qpts_sync #(.WIDTH(1)) u_busy_sync
    (
        .clk_in(bus_clk_in),
        .d_in(nv_busy_out),
        .q_out(busy_link)
    );

    // Bits are sampled on the rising clock edge; the slave drives after falling.
    always_ff @(posedge bus_clk_in)
    begin
        start_seen_q <= start_tgl_q;
        stop_seen_q <= stop_tgl_q;
        ack_q <= 1'b0;
        if (start_seen_q != start_tgl_q)
        begin
            state_q <= ST_ADDR;
            bitcnt_q <= 4'h1;
            shift_q <= {7'h00, sda_in};
        end
        else if (stop_seen_q != stop_tgl_q)
        begin
            state_q <= ST_IDLE;
            bitcnt_q <= 4'h0;
        end
        else if (state_q == ST_IDLE)
        begin
            bitcnt_q <= 4'h0;
        end
        else if (bitcnt_q == 4'h8)
        begin
            bitcnt_q <= 4'h0;
        end
        else if (state_q == ST_STEP)
        begin
            step_dir_q <= sda_in;
            step_tgl_q <= ~step_tgl_q;
        end
        else
        begin
            bitcnt_q <= bitcnt_q + 4'h1;
            shift_q <= shifted;
            if (bitcnt_q == 4'h7)
            begin
                unique case (state_q)
                    ST_ADDR:
                    begin
                        ack_q <= addr_match;
                        state_q <= addr_match ? ST_INSTR : ST_IDLE;
                    end
                    ST_INSTR:
                    begin
                        instr_q <= qpts_instr_s'(shifted);
                        ack_q <= 1'b1;
                        state_q <= ST_DATA;
                    end
                    ST_DATA:
                    begin
                        ack_q <= cmd_has_data;
                        cmd_link_q.data <= shifted[5:0];
                        cmd_tgl_q <= ~cmd_tgl_q;
                        state_q <= ST_IDLE;
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
        // The instruction byte has moved the state on to data by its acknowledge clock.
        if (state_q == ST_DATA && bitcnt_q == 4'h8)
        begin
            cmd_link_q.opcode <= instr_q.opcode;
            cmd_link_q.preset <= {instr_q.preset_select_hi, instr_q.preset_select_lo};
            cmd_link_q.pot <= {instr_q.pot_select_hi, instr_q.pot_select_lo};
            cmd_link_q.valid <= 1'b1;
            nv_cmd_q <= instr_is_nv;
            if (instr_is_step)
            begin
                cmd_tgl_q <= ~cmd_tgl_q;
                state_q <= ST_STEP;
            end
            else if (!cmd_has_data)
            begin
                cmd_tgl_q <= ~cmd_tgl_q;
                state_q <= instr_is_read ? ST_READ : ST_IDLE;
                rd_q <= read_data_sync;
            end
        end
    end

    // Acknowledge and read data are driven on the falling edge, clock low.
    always_ff @(negedge bus_clk_in)
    begin
        drive_q <= ack_q || read_pull;
    end

    // ==============================================================
    // System domain: crossings, command dispatch, write timer.
    // ==============================================================
    logic drive_q_sync;
    logic cmd_tgl_sync;
    logic step_tgl_sync;
    logic stop_tgl_sync;
    logic cmd_tgl_seen_q;
    logic step_tgl_seen_q;
    logic stop_tgl_seen_q;
    logic nv_pend_q;
    logic [31:0] nv_cnt_q;
    logic [1:0] pot_sel;
    logic step_dir_sync;
    logic wp_n_sync;

    qpts_sync #(.WIDTH(6)) u_sync
    (
        .clk_in(ref_clk_in),
        .d_in({drive_q, cmd_tgl_q, step_tgl_q, stop_tgl_q, step_dir_q, write_protect_n_in}),
        .q_out({drive_q_sync, cmd_tgl_sync, step_tgl_sync, stop_tgl_sync, step_dir_sync,
                wp_n_sync})
    );

    // The pin drive lags the bus side by about three system clocks, well inside the
    // low phase of a bus clock, so the acknowledge settles before the master samples.
    always_ff @(posedge ref_clk_in)
    begin
        sda_out <= 1'b0;
        sda_oe_n_out <= ~drive_q_sync;
    end
    assign pot_sel = cmd_link_q.pot;

    always_ff @(posedge ref_clk_in)
    begin
        cmd_tgl_seen_q <= cmd_tgl_sync;
        step_tgl_seen_q <= step_tgl_sync;
        stop_tgl_seen_q <= stop_tgl_sync;
        cmd_out <= '0;
        if (sys_rst_in)
        begin
            wiper_position_reg_out <= {4{QPTS_WIPER_RST}};
            nv_busy_out <= 1'b0;
            nv_pend_q <= 1'b0;
            nv_cnt_q <= 32'h0;
        end
        else
        begin
            if (cmd_tgl_sync != cmd_tgl_seen_q)
            begin
                cmd_out <= cmd_link_q;
                if (cmd_link_q.opcode == QPTS_OP_WR_WIPER)
                begin
                    wiper_position_reg_out[pot_sel] <= cmd_link_q.data;
                end
                nv_pend_q <= nv_cmd_q && wp_n_sync;
            end
            if (step_tgl_sync != step_tgl_seen_q)
            begin
                if (step_dir_sync && wiper_position_reg_out[pot_sel] != 6'h3F)
                begin
                    wiper_position_reg_out[pot_sel] <= wiper_position_reg_out[pot_sel] + 6'h01;
                end
                else if (!step_dir_sync && wiper_position_reg_out[pot_sel] != 6'h00)
                begin
                    wiper_position_reg_out[pot_sel] <= wiper_position_reg_out[pot_sel] - 6'h01;
                end
            end
            if (stop_tgl_sync != stop_tgl_seen_q && nv_pend_q)
            begin
                nv_pend_q <= 1'b0;
                nv_busy_out <= 1'b1;
                nv_cnt_q <= 32'(NV_WRITE_CYC);
            end
            else if (nv_busy_out)
            begin
                nv_cnt_q <= nv_cnt_q - 32'h1;
                nv_busy_out <= (nv_cnt_q > 32'h1);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_pot
            qpts_tap_decode u_tap
            (
                .clk_in(ref_clk_in),
                .wiper_in(wiper_position_reg_out[g]),
                .tap_on_out(tap_on_out[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// [qpts_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus master model
module qpts_master (
    output var logic scl_out, // Bus clock
    output var logic sda_out, // Data drive
    input wire logic sda_in // Line level
);
    logic [7:0] rx_byte;
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // The clock rests high between frames; data moves near the middle of the low phase.
    task automatic start_cond();
        #40 sda_out = 1'b1;
        #40 scl_out = 1'b1;
        #80 sda_out = 1'b0;
        #80 scl_out = 1'b0;
    endtask
    task automatic stop_cond();
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #80 sda_out = 1'b1;
        #80;
    endtask
    // A long low phase keeps an acknowledge release clear of the next rising clock.
    task automatic bit_cyc(input logic b, output logic seen);
        #50 sda_out = b;
        #60 scl_out = 1'b1;
        #49 seen = sda_in;
        #1 scl_out = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(d[i], s);
            rx_byte = {rx_byte[6:0], s};
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask
endmodule
`default_nettype wire

// [qpts_slave_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module qpts_slave_chk
    import qpts_pkg::*;
#(
    parameter int NV_WRITE_CYC = 200
)(
    input wire logic ref_clk_in, // Clock
    input wire logic sys_rst_in, // Reset
    input wire logic bus_clk_in, // Bus clock
    input wire logic sda_in, // Line
    input wire logic sda_out, // Drive
    input wire logic sda_oe_n_out, // Enable
    input wire logic write_protect_n_in, // Protect
    input wire logic [3:0][5:0] wiper_position_reg_out, // Wipers
    input wire logic [3:0][QPTS_TAPS-1:0] tap_on_out, // Taps
    input wire qpts_cmd_s cmd_out, // Command
    input wire logic nv_busy_out // Busy
);
    int busy_cnt_q;
    int busy_cnt_d;
    assign busy_cnt_d = nv_busy_out ? busy_cnt_q + 1 : 0;
    always_ff @(posedge ref_clk_in)
    begin
        busy_cnt_q <= sys_rst_in ? 0 : busy_cnt_d;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    drive_low_a: assert property (sda_out == 1'b0) else $error("line driven high");
    for (genvar p = 0; p < 4; p++)
    begin : g_pot
        tap_hot_a: assert property ($onehot(tap_on_out[p])) else $error("taps not one-hot");
        tap_follow_a: assert property (tap_on_out[p][$past(wiper_position_reg_out[p])])
            else $error("tap off wiper");
    end
    wp_block_a: assert property (!write_protect_n_in && !$past(write_protect_n_in)
        |-> !$rose(nv_busy_out)) else $error("write while protected");
    busy_len_a: assert property ($fell(nv_busy_out)
        |-> busy_cnt_q >= NV_WRITE_CYC - 1 && busy_cnt_q <= NV_WRITE_CYC + 1)
        else $error("busy length");
    busy_mute_a: assert property (nv_busy_out && $past(nv_busy_out, 4) |-> sda_oe_n_out)
        else $error("ack while busy");
    cmd_pulse_a: assert property (cmd_out.valid |=> !cmd_out.valid)
        else $error("command pulse long");
    start_quiet_a: assert property ($fell(sda_in) && bus_clk_in |-> sda_oe_n_out [*8])
        else $error("drive after start");
    cover property ($rose(nv_busy_out));
    cover property (cmd_out.valid && cmd_out.opcode == QPTS_OP_STEP);
    cover property ($fell(sda_oe_n_out));
endmodule
bind qpts_slave qpts_slave_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_chk (.ref_clk_in, .sys_rst_in,
    .bus_clk_in, .sda_in, .sda_out, .sda_oe_n_out, .write_protect_n_in,
    .wiper_position_reg_out, .tap_on_out, .cmd_out, .nv_busy_out);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import qpts_pkg::*;
    localparam int NV_CYC = 200;
    localparam logic [3:0] OPS [9] = '{QPTS_OP_RD_WIPER, QPTS_OP_WR_WIPER, QPTS_OP_RD_DATA,
        QPTS_OP_WR_DATA, QPTS_OP_XFR_D2W, QPTS_OP_XFR_W2D, QPTS_OP_GXFR_D2W,
        QPTS_OP_GXFR_W2D, QPTS_OP_STEP};
    localparam logic [5:0] WV [4] = '{6'h3F, 6'h20, 6'h01, 6'h2A};
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic scl;
    logic msda;
    logic dut_sda;
    logic oe_n;
    wire sda_line;
    logic [3:0] strap = 4'h0;
    logic wp_n = 1'b1;
    logic [3:0][5:0] wiper;
    logic [3:0][QPTS_TAPS-1:0] taps;
    qpts_cmd_s cmd;
    qpts_cmd_s last_cmd;
    logic busy;
    logic [7:0] addr;
    int err_total = 0;
    int compares = 0;
    // The line has a pull-up: it is low only where some party pulls it.
    assign sda_line = msda & (oe_n | dut_sda);
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (cmd.valid === 1'b1) last_cmd <= cmd;
    qpts_slave #(.NV_WRITE_CYC(NV_CYC)) u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .bus_clk_in(scl), .sda_in(sda_line), .sda_out(dut_sda), .sda_oe_n_out(oe_n),
        .strap_address_pins_in(strap), .write_protect_n_in(wp_n), .read_data_in(6'h15),
        .wiper_position_reg_out(wiper), .tap_on_out(taps), .cmd_out(cmd), .nv_busy_out(busy));
    qpts_master u_mst (.scl_out(scl), .sda_out(msda), .sda_in(sda_line));
    // ==========
    // Tasks
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d,
        input int nb, input logic [2:0] exp, input string what);
        logic [2:0] k;
        k = 3'h0;
        u_mst.start_cond();
        u_mst.xfer(a, k[2]);
        if (k[2] && nb > 1) u_mst.xfer(i, k[1]);
        if (k[1] && nb > 2) u_mst.xfer(d, k[0]);
        u_mst.stop_cond();
        repeat (6) @(negedge ref_clk_in);
        check(what, k, exp);
    endtask
    // The wiper is checked before the stop, whose own clock pulse would step it again.
    task automatic step(input logic [1:0] p, input logic [3:0] dirs, input int n,
        input logic [5:0] exp);
        logic [1:0] k;
        logic s;
        u_mst.start_cond();
        u_mst.xfer(addr, k[1]);
        u_mst.xfer({QPTS_OP_STEP, 2'b00, p}, k[0]);
        for (int j = 0; j < n; j++) u_mst.bit_cyc(dirs[j], s);
        repeat (6) @(negedge ref_clk_in);
        check("step", wiper[p], exp);
        u_mst.stop_cond();
        repeat (6) @(negedge ref_clk_in);
    endtask
    // ==========
    // Tests
    initial
    begin
        bit wr;
        bit rd;
        logic s;
        repeat (12) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        @(negedge ref_clk_in);
        check("busy", busy, 1'b0);
        for (int p = 0; p < 4; p++) check("tap", taps[p], 64'h1);
        $display("reset test done");
        for (int t = 0; t < 16; t++)
        begin
            strap = t[3:0];
            frame({QPTS_TYPE_CODE, 4'h6}, 8'h00, 8'h00, 1, {t == 6, 2'b00}, "strap");
        end
        strap = 4'h6;
        addr = {QPTS_TYPE_CODE, 4'h6};
        frame({~QPTS_TYPE_CODE, 4'h6}, 8'h00, 8'h00, 3, 3'b000, "type");
        $display("address test done");
        wp_n = 1'b0;
        for (int n = 0; n < 9; n++)
        begin
            wr = OPS[n] inside {QPTS_OP_WR_WIPER, QPTS_OP_WR_DATA};
            rd = OPS[n] inside {QPTS_OP_RD_WIPER, QPTS_OP_RD_DATA};
            frame(addr, {OPS[n], 4'h0}, {8{rd}}, (wr || rd) ? 3 : 2, {2'b11, wr}, "op");
            check("opcode", last_cmd.opcode, OPS[n]);
            if (rd) check("read", u_mst.rx_byte, 8'h15);
        end
        check("busy", busy, 1'b0);
        wp_n = 1'b1;
        $display("opcode test done");
        for (int p = 0; p < 4; p++)
        begin
            frame(addr, {QPTS_OP_WR_WIPER, 2'b00, p[1:0]}, {2'b00, WV[p]}, 3, 3'b111, "wr");
            check("wiper", wiper[p], WV[p]);
            check("pot", last_cmd.pot, p[1:0]);
            check("tap", taps[p], 64'h1 << WV[p]);
        end
        step(2'b01, 4'b0111, 4, 6'h22);
        step(2'b00, 4'b0001, 1, 6'h3F);
        $display("wiper test done");
        u_mst.start_cond();
        for (int j = 0; j < 4; j++) u_mst.bit_cyc(j[0], s);
        frame(addr, 8'h00, 8'h00, 1, 3'b100, "restart");
        frame(addr, {QPTS_OP_WR_DATA, 2'b10, 2'b11}, 8'h07, 3, 3'b111, "nv");
        check("busy", busy, 1'b1);
        check("preset", last_cmd.preset, 2'b10);
        frame(addr, 8'h00, 8'h00, 1, 3'b000, "poll");
        repeat (NV_CYC) @(negedge ref_clk_in);
        check("busy", busy, 1'b0);
        frame(addr, 8'h00, 8'h00, 1, 3'b100, "poll");
        $display("write test done");
        end_sim();
    end
    initial
    begin
        #1000000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
